// *** logic/bod_monitor.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: supply brown-out monitor control and reset-cause record
// Assumes: classic wishbone slave, comparator levels asynchronous
// Notes:   cause record is captured once, at the first enabled edge
//
// Operation
// - reset sets its own cause bit, clears others
// - sysreq bit6, watchdog bit5, pin bit4
// - supply bit2, core bit1, power-on bit0
// - cause record read-only byte at offset zero
// - byte, halfword and word accesses supported
// - guard blocks writes to protectable registers
// - sampling tick is 1 kHz over 2^(psel+1)
// - slow clock and comparator crossings are synchronised
// - band enable gives separate assert, release thresholds
// - band works in continuous and sampling mode
// - runs asleep only if enabled and kept
// - asleep select chooses sampling in standby
// - ready, sync-done and detect interrupt sources
// - flag set when the condition is evaluated, at the next tick in sampling mode
// - supply sources reset device, recorded in cause
//////////////////////////////////////////////////////////////////////////////
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bod_monitor (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        CE_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        WRITE_GUARD_I,
	input  wire logic        POWERON_SRC_I,
	input  wire logic        CORE_BOD_SRC_I,
	input  wire logic        SUPPLY_BOD_SRC_I,
	input  wire logic        PIN_RESET_SRC_I,
	input  wire logic        WATCHDOG_SRC_I,
	input  wire logic        SYSREQ_SRC_I,
	input  wire logic        STANDBY_I,
	input  wire logic        PRESCALER_CLK_I,
	input  wire logic        BELOW_ASSERT_I,
	input  wire logic        BELOW_RELEASE_I,
	output logic             BOD_RESET_O,
	output logic             IRQ_O
);

	typedef struct packed {
		logic                                ack;
		logic [31:0]                         dat;
		logic                                cause_pending;
		logic [bod_pkg::CAUSE_W-1:0]         cause;
		logic [bod_pkg::CTRL_W-1:0]          ctrl;
		logic [bod_pkg::CTRL_W-1:0]          live;
		logic [bod_pkg::SYNC_CNT_W-1:0]      sync_cnt;
		logic                                sync_busy;
		logic [bod_pkg::FLAG_W-1:0]          flags;
		logic [bod_pkg::FLAG_W-1:0]          mask;
		logic                                ba_meta;
		logic                                ba_sync;
		logic                                br_meta;
		logic                                br_sync;
		logic                                reset_req;
		logic                                ready;
		logic                                irq;
	} mon_state_t;

	mon_state_t s;
	mon_state_t next_s;
	logic       tick;
	logic       active;
	logic       sampling;
	logic       eval;
	logic       req;
	logic [31:0] wr_word;
	logic [bod_pkg::FLAG_W-1:0] set_ev;
	logic [bod_pkg::FLAG_W-1:0] clr_ev;

	// merge write data into a word by byte lane
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// one-hot cause, most fundamental source wins if several are seen
	function automatic logic [bod_pkg::CAUSE_W-1:0] pick_cause(input logic por, input logic core,
		input logic sup, input logic pin, input logic wdog, input logic sreq);
		logic [bod_pkg::CAUSE_W-1:0] c;
		c = '0;
		if (por) begin
			c[bod_pkg::CAUSE_POWERON] = 1'b1;
		end else if (core) begin
			c[bod_pkg::CAUSE_CORE] = 1'b1;
		end else if (sup) begin
			c[bod_pkg::CAUSE_SUPPLY] = 1'b1;
		end else if (pin) begin
			c[bod_pkg::CAUSE_PIN] = 1'b1;
		end else if (wdog) begin
			c[bod_pkg::CAUSE_WDOG] = 1'b1;
		end else if (sreq) begin
			c[bod_pkg::CAUSE_SYSREQ] = 1'b1;
		end else begin
			c[bod_pkg::CAUSE_POWERON] = 1'b1;
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	sample_tick u_tick (
		.clk_i      (SYS_CLK_I),
		.rst_n_i    (RSTN_I),
		.ce_i       (CE_I),
		.run_i      (active && sampling),
		.psel_i     (s.live[bod_pkg::CTRL_PSEL_LSB +: bod_pkg::CTRL_PSEL_W]),
		.slow_clk_i (PRESCALER_CLK_I),
		.tick_o     (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s  = s;
		set_ev  = '0;
		clr_ev  = '0;
		wr_word = '0;
		req     = WB_CYC_I && WB_STB_I && !s.ack;

		// comparator levels cross through two flops before use
		next_s.ba_meta = BELOW_ASSERT_I;
		next_s.ba_sync = s.ba_meta;
		next_s.br_meta = BELOW_RELEASE_I;
		next_s.br_sync = s.br_meta;

		// capture the reset cause once after release
		if (s.cause_pending) begin
			next_s.cause = pick_cause(POWERON_SRC_I, CORE_BOD_SRC_I, SUPPLY_BOD_SRC_I,
				PIN_RESET_SRC_I, WATCHDOG_SRC_I, SYSREQ_SRC_I);
			next_s.cause_pending = 1'b0;
		end

		// monitor operating mode
		active   = s.live[bod_pkg::CTRL_ENABLE] &&
			(!STANDBY_I || s.live[bod_pkg::CTRL_KEEP_ASLEEP]);
		sampling = STANDBY_I ? s.live[bod_pkg::CTRL_ASLEEP_SAMPL]
			: s.live[bod_pkg::CTRL_ACT_SAMPLING];
		eval     = active && (sampling ? tick : 1'b1);

		// same threshold logic for both modes, only the eval strobe differs
		if (!s.live[bod_pkg::CTRL_ENABLE]) begin
			next_s.reset_req = 1'b0;
			next_s.ready     = 1'b0;
		end else if (eval) begin
			if (s.ba_sync) begin
				next_s.reset_req = 1'b1;
				if (!s.reset_req) begin
					set_ev[bod_pkg::FLAG_DET] = 1'b1;
				end
			end else if (!s.live[bod_pkg::CTRL_BAND] || !s.br_sync) begin
				next_s.reset_req = 1'b0;
			end
			if (!s.ready) begin
				next_s.ready = 1'b1;
				set_ev[bod_pkg::FLAG_READY] = 1'b1;
			end
		end

		// control settles into the monitor after a fixed crossing delay
		if (s.sync_busy) begin
			if (s.sync_cnt == (bod_pkg::SYNC_CNT_W)'(bod_pkg::SYNC_CYCLES - 1)) begin
				next_s.live      = s.ctrl;
				next_s.sync_busy = 1'b0;
				set_ev[bod_pkg::FLAG_SYNC] = 1'b1;
			end else begin
				next_s.sync_cnt = s.sync_cnt + 1'b1;
			end
		end

		// wishbone: answer one cycle after the request is seen
		next_s.ack = req;
		if (req) begin
			next_s.dat = '0;
			unique case (WB_ADR_I)
				bod_pkg::OFS_CAUSE: begin
					next_s.dat[bod_pkg::CAUSE_W-1:0] = s.cause;
				end
				bod_pkg::OFS_CTRL: begin
					next_s.dat[bod_pkg::CTRL_W-1:0] = s.ctrl;
					wr_word = merge_lanes({20'h0_0000, s.ctrl}, WB_DAT_I, WB_SEL_I);
					if (WB_WE_I && !WRITE_GUARD_I) begin
						next_s.ctrl      = wr_word[bod_pkg::CTRL_W-1:0] & bod_pkg::CTRL_WRITABLE;
						next_s.sync_busy = 1'b1;
						next_s.sync_cnt  = '0;
					end
				end
				bod_pkg::OFS_FLAGS: begin
					next_s.dat[bod_pkg::FLAG_W-1:0] = s.flags;
					if (WB_WE_I && WB_SEL_I[0]) begin
						clr_ev = WB_DAT_I[bod_pkg::FLAG_W-1:0];
					end
				end
				bod_pkg::OFS_MASK: begin
					next_s.dat[bod_pkg::FLAG_W-1:0] = s.mask;
					if (WB_WE_I && WB_SEL_I[0] && !WRITE_GUARD_I) begin
						next_s.mask = WB_DAT_I[bod_pkg::FLAG_W-1:0];
					end
				end
				bod_pkg::OFS_STATUS: begin
					next_s.dat[bod_pkg::STAT_RESET_REQ] = s.reset_req;
					next_s.dat[bod_pkg::STAT_SYNC_BUSY] = s.sync_busy;
					next_s.dat[bod_pkg::STAT_READY]     = s.ready;
				end
				default: begin
					next_s.dat = '0;
				end
			endcase
		end

		// a new event wins over a clear in the same cycle
		next_s.flags = (s.flags & ~clr_ev) | set_ev;
		next_s.irq   = |(next_s.flags & next_s.mask);
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s               <= '0;
			s.cause_pending <= 1'b1;
			s.ctrl          <= bod_pkg::CTRL_RESET;
			s.live          <= bod_pkg::CTRL_RESET;
			s.mask          <= bod_pkg::MASK_RESET;
		end else if (CE_I) begin
			s <= next_s;
		end
	end

	assign WB_DAT_O    = s.dat;
	assign WB_ACK_O    = s.ack;
	assign BOD_RESET_O = s.reset_req;
	assign IRQ_O       = s.irq;

endmodule
`default_nettype wire

// *** logic/bod_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the supply monitor and the reset-cause record
// Assumes: 32-bit wishbone data, byte addresses, 20 MHz system clock
// Notes:   offsets are byte addresses of aligned words
//////////////////////////////////////////////////////////////////////////////
package bod_pkg;

	// register map (byte addresses)
	localparam logic [7:0]  OFS_CAUSE  = 8'h00;
	localparam logic [7:0]  OFS_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_FLAGS  = 8'h08;
	localparam logic [7:0]  OFS_MASK   = 8'h0C;
	localparam logic [7:0]  OFS_STATUS = 8'h10;

	// reset-cause record bit positions
	localparam int CAUSE_POWERON = 0;
	localparam int CAUSE_CORE    = 1;
	localparam int CAUSE_SUPPLY  = 2;
	localparam int CAUSE_PIN     = 4;
	localparam int CAUSE_WDOG    = 5;
	localparam int CAUSE_SYSREQ  = 6;
	localparam int CAUSE_W       = 8;

	// control register fields
	localparam int CTRL_ENABLE       = 1;
	localparam int CTRL_BAND         = 2;
	localparam int CTRL_ACT_SAMPLING = 3;
	localparam int CTRL_ASLEEP_SAMPL = 5;
	localparam int CTRL_KEEP_ASLEEP  = 6;
	localparam int CTRL_PSEL_LSB     = 8;
	localparam int CTRL_PSEL_W       = 4;
	localparam int CTRL_W            = 12;
	localparam logic [11:0] CTRL_RESET     = 12'h000;
	localparam logic [11:0] CTRL_WRITABLE  = 12'hF6E;

	// interrupt flag / mask bits
	localparam int FLAG_READY = 0;
	localparam int FLAG_DET   = 1;
	localparam int FLAG_SYNC  = 2;
	localparam int FLAG_W     = 3;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// status register bits
	localparam int STAT_RESET_REQ = 0;
	localparam int STAT_SYNC_BUSY = 1;
	localparam int STAT_READY     = 2;

	// timing
	localparam int CLK_FREQ_HZ  = 20_000_000;
	localparam int PRESCALE_HZ  = 1_000;
	localparam int SYNC_TIME_NS = 200;
	localparam int SYNC_CYCLES  = (SYNC_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int SYNC_CNT_W   = 4;
	localparam int TICK_CNT_W   = 17;

endpackage

// *** logic/sample_tick.sv ***
//////////////////////////////////////////////////////////////////////////////
// Purpose: sampling tick from the slow prescaler clock
// Assumes: prescaler clock is far slower than the system clock
// Notes:   one tick every 2^(psel+1) prescaler periods
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module sample_tick (
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic                          ce_i,
	input  wire logic                          run_i,
	input  wire logic [bod_pkg::CTRL_PSEL_W-1:0] psel_i,
	input  wire logic                          slow_clk_i,
	output logic                               tick_o
);

	typedef struct packed {
		logic                          meta;
		logic                          sync;
		logic                          prev;
		logic [bod_pkg::TICK_CNT_W-1:0] cnt;
		logic                          tick;
	} tick_state_t;

	tick_state_t s;
	tick_state_t next_s;
	logic [bod_pkg::TICK_CNT_W-1:0] last;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s      = s;
		next_s.meta = slow_clk_i;
		next_s.sync = s.meta;
		next_s.prev = s.sync;
		next_s.tick = 1'b0;
		last        = (bod_pkg::TICK_CNT_W)'((32'd2 << psel_i) - 32'd1);
		if (!run_i) begin
			next_s.cnt = '0;
		end else if (s.sync && !s.prev) begin
			// divide the 1 kHz edges by two to the power psel+1
			if (s.cnt >= last) begin
				next_s.cnt  = '0;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

endmodule
`default_nettype wire

// *** bench/bod_monitor_checker.sv ***
// Purpose: port checks for bod_monitor
// Assumes: one clock, async active-low reset, CE_I high while checked
// Notes:   comparator latency is two sync flops plus the output flop
`timescale 1ns/10ps
`default_nettype none
module bod_monitor_checker (
	input wire logic        SYS_CLK_I,
	input wire logic        RSTN_I,
	input wire logic        CE_I,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [7:0]  WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	input wire logic        BELOW_ASSERT_I,
	input wire logic        BOD_RESET_O,
	input wire logic        IRQ_O
);
	logic [3:0] since_high;
	logic       mapped;
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	assign mapped = WB_ADR_I inside {bod_pkg::OFS_CAUSE, bod_pkg::OFS_CTRL, bod_pkg::OFS_FLAGS, bod_pkg::OFS_MASK,
		bod_pkg::OFS_STATUS};
	// edges since the comparator was last high; saturates so it never wraps
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			since_high <= 4'h0;
		else if (CE_I)
			since_high <= BELOW_ASSERT_I ? 4'h0 : since_high + {3'h0, since_high != 4'hf};
	end
	sequence s_take;
		CE_I && WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence s_read(logic [7:0] a);
		WB_ACK_O && !WB_WE_I && WB_ADR_I == a;
	endsequence
	property p_ack_next;
		s_take |=> WB_ACK_O;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack after request");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_cause_ro;
		s_read(bod_pkg::OFS_CAUSE) |-> WB_DAT_O[31:7] == 25'h000_0000 && !WB_DAT_O[3];
	endproperty
	a_cause_ro: assert property (p_cause_ro) else $error("cause has unused bits set");
	property p_cause_one;
		s_read(bod_pkg::OFS_CAUSE) |-> $onehot(WB_DAT_O[6:0]);
	endproperty
	a_cause_one: assert property (p_cause_one) else $error("cause not one-hot");
	property p_unmapped;
		WB_ACK_O && !WB_WE_I && !mapped |-> WB_DAT_O == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rise;
		$rose(BOD_RESET_O) |-> since_high <= 4'h3;
	endproperty
	a_rise: assert property (p_rise) else $error("reset request without low supply");
	property p_fall;
		$fell(BOD_RESET_O) |-> since_high >= 4'h3;
	endproperty
	a_fall: assert property (p_fall) else $error("reset request dropped while low");
	property p_rst;
		$rose(RSTN_I) |-> !WB_ACK_O && !IRQ_O && !BOD_RESET_O;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
endmodule
bind bod_monitor bod_monitor_checker chk_i (.SYS_CLK_I, .RSTN_I, .CE_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
	.WB_DAT_O, .WB_ACK_O, .BELOW_ASSERT_I, .BOD_RESET_O, .IRQ_O);
`default_nettype wire

// *** bench/supply_model.sv ***
// Purpose: supply comparator pair and prescaler clock
// Assumes: level 0 above both, 1 between, 2 below both thresholds
// Notes:   prescaler clock scaled down to keep runs short
`timescale 1ns/10ps
`default_nettype none
module supply_model #(
	parameter int HALF = 20
) (
	input  wire logic       clk_i,
	input  wire logic [1:0] level_i,
	output logic            below_assert_o,
	output logic            below_release_o,
	output logic            pclk_o
);
	int cnt = 0;
	// lower threshold sits under the upper one, so assert implies release
	assign below_assert_o  = level_i == 2'h2;
	assign below_release_o = level_i != 2'h0;
	// free-running prescaler, not 1 kHz: a real period would take 20000 cycles
	assign pclk_o = cnt >= HALF;
	always @(posedge clk_i)
		cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
endmodule
`default_nettype wire

// *** bench/bod_monitor_tb_top.sv ***
// Purpose: self-checking bench for bod_monitor
// Assumes: CE_I held high, prescaler half period of 20 cycles
// Notes:   random lane writes from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module bod_monitor_tb_top;
	logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, guard = 1'h0, stby = 1'h0;
	logic        ack, ba, br, pclk, bod, irq;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, rdat, dout;
	logic [5:0]  src = 6'h01;
	logic [1:0]  lvl = 2'h0;
	int          fails = 0, checks_done = 0, seed = 32'h7a94;
	always #25 clk = ~clk;
	bod_monitor dut (.SYS_CLK_I(clk), .RSTN_I(rst_n), .CE_I(1'h1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_ACK_O(ack), .WRITE_GUARD_I(guard),
		.POWERON_SRC_I(src[0]), .CORE_BOD_SRC_I(src[1]), .SUPPLY_BOD_SRC_I(src[2]), .PIN_RESET_SRC_I(src[3]),
		.WATCHDOG_SRC_I(src[4]), .SYSREQ_SRC_I(src[5]), .STANDBY_I(stby), .PRESCALER_CLK_I(pclk),
		.BELOW_ASSERT_I(ba), .BELOW_RELEASE_I(br), .BOD_RESET_O(bod), .IRQ_O(irq));
	supply_model #(.HALF(20)) sup (.clk_i(clk), .level_i(lvl), .below_assert_o(ba), .below_release_o(br),
		.pclk_o(pclk));
	function automatic logic [31:0] cause_bit(input int i);
		return 32'h0000_0001 << ((i < 3) ? i : i + 1);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] c, input logic [31:0] d, input logic [3:0] s);
		for (int k = 0; k < 4; k++)
			if (s[k]) c[8*k+:8] = d[8*k+:8];
		return c & {20'h0_0000, bod_pkg::CTRL_WRITABLE};
	endfunction
	task automatic test_done;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	// classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		for (n = 0; n < 20 && ack !== 1'h1; n++)
			@(posedge clk);
		rdat = dout;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n >= 20) begin
			chk(32'h0, 32'h1);
			test_done();
		end
	endtask
	task automatic wait_bod(input logic v, input int lim);
		int n;
		for (n = 0; n < lim && bod !== v; n++)
			@(posedge clk);
		chk(32'(bod), 32'(v));
		if (bod !== v)
			test_done();
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] c, d;
		logic [3:0]  s;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			src <= 6'h01 << i;
			rst_n <= 1'h0;
			repeat (2) @(posedge clk);
			rst_n <= 1'h1;
			wb(1'h1, bod_pkg::OFS_CAUSE, 4'hf, 32'hffff_ffff);
			wb(1'h0, bod_pkg::OFS_CAUSE, 4'h1, 32'h0);
			chk(rdat, cause_bit(i));
		end
		wb(1'h1, 8'h14, 4'hf, 32'hffff_ffff);
		wb(1'h0, 8'h14, 4'hf, 32'h0);
		chk(rdat, 32'h0);
		$display("cause test done");
		c = 32'h0;
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			s = $random(seed);
			d[1] = 1'h0;
			wb(1'h1, bod_pkg::OFS_CTRL, s, d);
			c = merge(c, d, s);
			repeat (8) @(posedge clk);
			wb(1'h0, bod_pkg::OFS_CTRL, 4'hf, 32'h0);
			chk(rdat, c);
		end
		guard <= 1'h1;
		wb(1'h1, bod_pkg::OFS_CTRL, 4'hf, ~c);
		repeat (8) @(posedge clk);
		wb(1'h0, bod_pkg::OFS_CTRL, 4'hf, 32'h0);
		chk(rdat, c);
		guard <= 1'h0;
		$display("lane test done");
		wb(1'h1, bod_pkg::OFS_MASK, 4'h1, 32'h4);
		wb(1'h1, bod_pkg::OFS_FLAGS, 4'h1, 32'h0);
		chk(32'(irq), 32'h1);
		wb(1'h1, bod_pkg::OFS_FLAGS, 4'h1, 32'h4);
		@(posedge clk);
		chk(32'(irq), 32'h0);
		wb(1'h1, bod_pkg::OFS_CTRL, 4'h1, 32'h0);
		repeat (8) @(posedge clk);
		chk(32'(irq), 32'h1);
		$display("irq test done");
		wb(1'h1, bod_pkg::OFS_MASK, 4'h1, 32'h2);
		for (int i = 0; i < 4; i++) begin
			// enable, band on odd steps, sampling with psel 1 (divide by 4) on upper steps
			d = 32'h2 | (i[0] ? 32'h4 : 32'h0) | (i[1] ? 32'h108 : 32'h0);
			wb(1'h1, bod_pkg::OFS_CTRL, 4'h3, d);
			wb(1'h1, bod_pkg::OFS_FLAGS, 4'h1, 32'h7);
			lvl <= 2'h2;
			wait_bod(1'h1, i[1] ? 200 : 20);
			@(posedge clk);
			chk(32'(irq), 32'h1);
			lvl <= 2'h1;
			repeat (300) @(posedge clk);
			chk(32'(bod), 32'(i[0]));
			lvl <= 2'h0;
			wait_bod(1'h0, 200);
		end
		$display("monitor test done");
		wb(1'h1, bod_pkg::OFS_CTRL, 4'h3, 32'h2);
		stby <= 1'h1;
		repeat (10) @(posedge clk);
		lvl <= 2'h2;
		repeat (100) @(posedge clk);
		chk(32'(bod), 32'h0);
		wb(1'h1, bod_pkg::OFS_CTRL, 4'h3, 32'h42);
		wait_bod(1'h1, 20);
		lvl <= 2'h0;
		wait_bod(1'h0, 20);
		wb(1'h1, bod_pkg::OFS_CTRL, 4'h3, 32'h62);
		lvl <= 2'h2;
		wait_bod(1'h1, 200);
		wb(1'h0, bod_pkg::OFS_STATUS, 4'hf, 32'h0);
		chk(rdat, 32'h0000_0005);
		$display("standby test done");
		test_done();
	end
endmodule
`default_nettype wire
